// >>> bench/ipvs_core_model.sv
/* ipvs_core_model: instruction stream of the execution unit.
   Assumes the bench supplies each next instruction length. */
`timescale 1ns/1ps
module ipvs_core_model (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_vec_busy,
  input wire [1:0] i_len,
  output reg o_last_cycle,
  output reg o_instr_end
);
  reg [2:0] left_q;
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) left_q <= 3'h1;
    else if (o_last_cycle) left_q <= {1'h0, i_len} + 3'h1;
    else if (!i_vec_busy) left_q <= left_q - 3'h1;
  end
  always @* begin
    o_last_cycle = left_q == 3'h1 && !i_vec_busy;
    o_instr_end = o_last_cycle;
  end
endmodule

// >>> bench/ipvs_props.sv
/* ipvs_props: port checks of ipvs_top, bound at the foot.
   Assumes one clock i_mclk and async active-low i_rst_n. */
`timescale 1ns/1ps
module ipvs_props (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire i_last_cycle,
  input wire i_instr_end,
  input wire i_ret_stacked_context_select,
  input wire i_call_sub,
  input wire o_ctx_req,
  input wire o_vec_busy,
  input wire o_pc_load,
  input wire [23:0] o_vector_addr,
  input wire o_call_push_valid,
  input wire [2:0] o_stack_count
);
  reg [2:0] win_q;
  reg [1:0] hold_q;
  reg [6:0] busy_q;
  ////////////////////////////////////////////////////////////
  // window phase, hold count, busy length
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_q <= 3'h0;
      hold_q <= 2'h2;
      busy_q <= 7'h0;
    end else begin
      win_q <= win_q + 3'h1;
      busy_q <= o_vec_busy ? busy_q + 7'h1 : 7'h0;
      if (i_ret_stacked_context_select || (i_avs_write && !o_avs_waitrequest && !i_avs_address[3])) begin
        hold_q <= 2'h0;
      end else if (i_instr_end && hold_q != 2'h2) begin
        hold_q <= hold_q + 2'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req_state; o_ctx_req [*2] ##1 !o_ctx_req; endsequence
  sequence s_entry; $rose(o_ctx_req) && $rose(o_vec_busy); endsequence
  property p_req_two; $rose(o_ctx_req) |-> s_req_state; endproperty
  a_req_two: assert property (p_req_two) else $error("request state length");
  property p_window; $rose(o_ctx_req) |-> win_q == 3'h0; endproperty
  a_window: assert property (p_window) else $error("request off window");
  property p_switch_len; o_pc_load |-> busy_q >= 7'h18 && busy_q <= 7'h5C && !busy_q[0]; endproperty
  a_switch_len: assert property (p_switch_len) else $error("switch length");
  property p_single; $rose(o_ctx_req) |-> s_entry; endproperty
  a_single: assert property (p_single) else $error("overlapping vector");
  property p_last; $rose(o_ctx_req) |-> $past(i_last_cycle); endproperty
  a_last: assert property (p_last) else $error("vector mid instruction");
  property p_hold; $rose(o_ctx_req) |-> $past(hold_q) == 2'h2; endproperty
  a_hold: assert property (p_hold) else $error("vector too soon");
  property p_load_end; o_pc_load |-> !o_vec_busy && $past(o_vec_busy); endproperty
  a_load_end: assert property (p_load_end) else $error("load outside vector");
  property p_vec_addr; o_pc_load |-> o_vector_addr == 24'h00007B || o_vector_addr[23:3] < 21'h8 && o_vector_addr[2:0] == 3'h3; endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector spacing");
  property p_call; i_call_sub |=> o_call_push_valid && o_stack_count == 3'h2; endproperty
  a_call: assert property (p_call) else $error("call push count");
endmodule
bind ipvs_top ipvs_props u_props (.i_mclk, .i_rst_n, .i_avs_address, .i_avs_write, .o_avs_waitrequest,
  .i_last_cycle, .i_instr_end, .i_ret_stacked_context_select, .i_call_sub, .o_ctx_req, .o_vec_busy, .o_pc_load,
  .o_vector_addr, .o_call_push_valid, .o_stack_count);

// >>> bench/test_ipvs_top.sv
/* test_ipvs_top: self-checking bench of ipvs_top with a core model.
   Assumes a 20 MHz clock and the register map of the design. */
`timescale 1ns/1ps
module test_ipvs_top;
  reg mclk;
  reg rst_n = 1'h0;
  reg rd = 1'h0;
  reg wr = 1'h0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg pin_a_n = 1'h1;
  reg pin_b_n = 1'h1;
  reg [5:0] ireq = 6'h0;
  reg [3:0] ev = 4'h0;
  reg [23:0] pc = 24'h0;
  reg [7:0] st = 8'h0;
  reg [4:0] knob = 5'h0;
  reg [3:0] ws = 4'h0;
  reg [1:0] len = 2'h0;
  reg [31:0] seed = 32'hDFACF7CF;
  reg [31:0] lseed = 32'hDFACF7CF;
  reg [39:0] exp_q[$];
  reg ctx_d = 1'h0;
  reg stk;
  reg [15:0] prio;
  integer cyc = 0;
  integer i;
  integer bad_count = 0;
  integer samples_checked = 0;
  wire [31:0] rdata;
  wire wreq, last, iend, ctx, busy, pv, pl, popv, cpv;
  wire [7:0] pd;
  wire [23:0] va;
  wire [2:0] sc;
  ipvs_top dut_u (.i_mclk(mclk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_ext_irq_pin_a_n(pin_a_n), .i_ext_irq_pin_b_n(pin_b_n), .i_int_req(ireq), .i_last_cycle(last),
    .i_instr_end(iend), .i_ret_stacked_context_select(ev[0]), .i_ret_sub(ev[1]), .i_call_sub(ev[2]), .i_trap(ev[3]),
    .i_pc(pc), .i_ext_status(st), .i_ext_exec(knob[0]), .i_page_mode(knob[1]), .i_far_isr(knob[2]),
    .i_ext_stack(knob[3]), .i_far_stack(knob[4]), .i_wait_states(ws), .o_ctx_req(ctx), .o_vec_busy(busy),
    .o_push_valid(pv), .o_push_data(pd), .o_pc_load(pl), .o_vector_addr(va), .o_pop_valid(popv),
    .o_call_push_valid(cpv), .o_stack_count(sc));
  ipvs_core_model core_u (.i_mclk(mclk), .i_rst_n(rst_n), .i_vec_busy(busy), .i_len(len),
    .o_last_cycle(last), .o_instr_end(iend));
  ////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task check(input [39:0] seen, input [39:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task take(input [39:0] seen);
    begin
      if (exp_q.size() == 0) check(seen, 40'h0);
      else check(seen, exp_q.pop_front());
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk);
      while (wreq !== 1'h0 && n < 100) begin
        @(posedge mclk);
        n = n + 1;
      end
      if (wreq !== 1'h0) bad_count = bad_count + 1;
      wr <= 1'h0;
      rd <= 1'h0;
    end
  endtask
  task rdchk(input [3:0] a, input [31:0] d);
    begin
      exp_q.push_back({8'h04, d});
      bus(1'h0, a, 32'h0);
    end
  endtask
  task strobe(input [3:0] m);
    begin
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 4'h0;
    end
  endtask
  task req(input [3:0] s, input v);
    begin
      @(posedge mclk);
      if (s == 4'h0) pin_a_n <= !v;
      else if (s == 4'h2) pin_b_n <= !v;
      else ireq[(s == 4'h1) ? 4'h0 : s - 4'h2] <= v;
    end
  endtask
  task expvec(input [3:0] s, input k);
    integer n;
    begin
      seed = xs(seed);
      pc <= seed[23:0];
      st <= seed[31:24];
      exp_q.push_back({32'h01000000, seed[7:0]});
      exp_q.push_back({32'h01000000, seed[15:8]});
      if (k) exp_q.push_back({32'h01000000, seed[23:16]});
      if (k) exp_q.push_back({32'h01000000, seed[31:24]});
      exp_q.push_back({16'h0200, s == 4'h8 ? 24'h00007B : 24'h000003 + {17'h0, s, 3'h0}});
      seed = xs(seed);
      knob <= seed[4:0];
      ws <= {2'h0, seed[6:5]};
      n = 11 + 2 * seed[0] + seed[1] + 8 * seed[2] + (seed[3] ? (seed[4] ? 8 : 4) : 0) + seed[6:5];
      n = 2 + 2 * n;
      exp_q.push_back({8'h05, n});
    end
  endtask
  task drain;
    integer n;
    begin
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
        @(posedge mclk);
        n = n + 1;
      end
      check({8'h0, exp_q.size()}, 40'h0);
      repeat (12) @(posedge mclk);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    lseed <= xs(lseed);
    len <= lseed[1:0];
  end
  always @(negedge mclk) begin
    if (rst_n) begin
      if (ctx === 1'h1 && !ctx_d) cyc = 0;
      else cyc = cyc + 1;
      ctx_d = ctx;
      if (pv === 1'h1) take({32'h01000000, pd});
      if (pl === 1'h1) take({16'h0200, va});
      if (pl === 1'h1) take({8'h05, cyc});
      if (popv === 1'h1) take({8'h03, 29'h0, sc});
      if (cpv === 1'h1) take({8'h06, 29'h0, sc});
      if (rd && wreq === 1'h0) take({8'h04, rdata});
    end
  end
  // about 60000 cycles, far above the expected run
  initial begin
    #3000000;
    bad_count = bad_count + 1;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    rdchk(4'h0, 32'h0);
    rdchk(4'h4, 32'h0);
    prio = 16'h0;
    for (i = 0; i < 8; i = i + 1) prio = prio | ((16'h1 + i % 3) << (2 * i));
    bus(1'h1, 4'h4, {16'h0, prio});
    rdchk(4'h4, {16'h0, prio});
    bus(1'h1, 4'hC, 32'hFFFFFFFF);
    rdchk(4'hC, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      stk = i[0];
      bus(1'h1, 4'h0, {23'h0, stk, 8'hFF});
      expvec(i[3:0], stk);
      req(i[3:0], 1'h1);
      drain;
      req(i[3:0], 1'h0);
      // let the latched request refresh before the return lifts the block
      repeat (16) @(posedge mclk);
      exp_q.push_back({8'h03, 29'h0, stk ? 3'h4 : 3'h2});
      strobe(4'h1);
      drain;
    end
    rdchk(4'h0, 32'h000001FF);
    expvec(4'h5, 1'h1);
    @(posedge mclk);
    ireq <= 6'h0A;
    drain;
    req(4'h5, 1'h0);
    req(4'h0, 1'h1);
    repeat (40) @(posedge mclk);
    req(4'h0, 1'h0);
    repeat (80) @(posedge mclk);
    exp_q.push_back({8'h03, 32'h4});
    strobe(4'h1);
    expvec(4'h3, 1'h1);
    drain;
    req(4'h3, 1'h0);
    repeat (16) @(posedge mclk);
    exp_q.push_back({8'h03, 32'h4});
    strobe(4'h1);
    drain;
    expvec(4'h8, 1'h1);
    strobe(4'h8);
    drain;
    exp_q.push_back({8'h03, 32'h2});
    strobe(4'h2);
    drain;
    exp_q.push_back({8'h06, 32'h2});
    strobe(4'h4);
    drain;
    rdchk(4'h8, 32'h00080000);
    bus(1'h1, 4'h8, 32'hFFFFFFFF);
    rdchk(4'h8, 32'h00080000);
    stop_test;
  end
endmodule

// >>> rtl/ipvs_defines.vh
/*
  Constants of the interrupt poll and vector sequencer: state-time phasing,
  context-switch state counts, stack byte counts, vector addresses and
  register map. Assumes inclusion by bare name from the rtl/ files.
*/
`ifndef IPVS_DEFINES_VH
`define IPVS_DEFINES_VH

// state time = two core clocks: first half, second half
`define IPVS_HALF_FIRST 1'h0
`define IPVS_HALF_LAST 1'h1
`define IPVS_SLOT_STEP 2'h1
`define IPVS_SLOT_LAST 2'h3

// request sources
`define IPVS_NSRC 8
`define IPVS_SRC_TRAP 4'h8

// context switch lengths in state times
`define IPVS_CTX_STATES 6'h0B
`define IPVS_ADD_EXT_EXEC 6'h02
`define IPVS_ADD_PAGE 6'h01
`define IPVS_ADD_FAR_ISR 6'h08
`define IPVS_ADD_STK_NEAR 6'h04
`define IPVS_ADD_STK_FAR 6'h08
`define IPVS_CNT_ONE 6'h01

// bytes moved on the stack
`define IPVS_PUSH_CTX 3'h4
`define IPVS_PUSH_PC 3'h2
`define IPVS_BYTE_STEP 3'h1

// instructions that must complete after a blocking instruction
`define IPVS_HOLD_INSTR 2'h2
`define IPVS_HOLD_STEP 2'h1

// vector addresses (plain defaults, not tied to any memory map)
`define IPVS_VEC_BASE 24'h000003
`define IPVS_VEC_STEP_SH 3
`define IPVS_VEC_TRAP 24'h00007B

// register map, byte addresses
`define IPVS_ADDR_CTRL 4'h0
`define IPVS_ADDR_PRIO 4'h4
`define IPVS_ADDR_STAT 4'h8
`define IPVS_CTRL_STK_BIT 8

`endif

// >>> rtl/ipvs_pair_latch.v
/*
  Sampler for one pair of request sources served in one state time of the
  four-state window. Internal sources latch in the first half of their slot;
  pin sources are sampled there and reach the poll in the second half of the
  following state. Assumes the window counter comes from the top module.
*/
`include "ipvs_defines.vh"
`timescale 1ns/1ps
module ipvs_pair_latch #(
  parameter [1:0] SLOT = 2'h0,
  parameter [0:0] EXT_LO = 1'h0,
  parameter [0:0] EXT_HI = 1'h0
) (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_half,
  input wire [1:0] i_slot,
  input wire [1:0] i_src,
  output reg [1:0] o_pend
);
  localparam [1:0] NEXT = SLOT + `IPVS_SLOT_STEP;
  wire [1:0] ext = {EXT_HI, EXT_LO};
  wire own_first = (i_half == `IPVS_HALF_FIRST) && (i_slot == SLOT);
  wire next_last = (i_half == `IPVS_HALF_LAST) && (i_slot == NEXT);
  reg [1:0] samp_q;
  integer k;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_q <= 2'h0;
      o_pend <= 2'h0;
    end else begin
      // (RULE_02) two sources per state
      if (own_first)
        samp_q <= i_src;
      for (k = 0; k < 2; k = k + 1) begin
        // (RULE_15) fresh value each window
        if (!ext[k] && own_first)
          o_pend[k] <= i_src[k];
        // (RULE_04) one extra state for pins
        // (RULE_05) sample first half, poll next state
        if (ext[k] && next_last)
          o_pend[k] <= samp_q[k];
      end
    end
  end
endmodule

// >>> rtl/ipvs_top.v
/*
  Interrupt poll and vector sequencer: samples eight requests over a
  four-state window, applies priority and blocking, asks the core for a
  context switch and paces the vector cycle with its stack pushes.
  Assumes an Avalon-MM master with waitrequest and a core that pulses
  instruction-end, return and call events synchronous to i_mclk.
*/
// Behaviour
// (RULE_01) Every request source is sampled and polled once per four-state window.
// (RULE_02) Two of the eight sources are latched and polled in each state time.
// (RULE_03) One request state, then eleven switch states: twelve states minimum.
// (RULE_04) Pin requests take one state more: six states versus five internal.
// (RULE_05) Pin sampled in first half, poll and request in next state's second half.
// (RULE_06) External requester holds its pin active at least five state times.
// (RULE_07) A pin going active after its sample waits three states for resampling.
// (RULE_08) Only one prioritized, enabled request starts a vector cycle at a time.
// (RULE_09) Vectoring blocked while equal or higher level is in service.
// (RULE_10) Vectoring only when the poll falls in the instruction's final cycle.
// (RULE_11) After return or enable/priority write, one more instruction runs first.
// (RULE_12) Vector cycle breaks the stream, pushes program counter, loads routine address.
// (RULE_13) With stacked-context bit set, four bytes pushed on entry and popped on return.
// (RULE_14) Subroutine call and return move only the two low program-counter bytes.
// (RULE_15) Blocked requests are not retained; a cleared level request is dropped.
// (RULE_16) Routine start addresses are eight bytes apart; trap vector is separate.
// (RULE_17) Switch lengthens per condition: execution, page, far routine, stack, waits.
// (RULE_18) Sampling window runs from a free counter cleared by reset.
`include "ipvs_defines.vh"
`timescale 1ns/1ps
module ipvs_top (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_ext_irq_pin_a_n,
  input wire i_ext_irq_pin_b_n,
  input wire [5:0] i_int_req,
  input wire i_last_cycle,
  input wire i_instr_end,
  input wire i_ret_stacked_context_select,
  input wire i_ret_sub,
  input wire i_call_sub,
  input wire i_trap,
  input wire [23:0] i_pc,
  input wire [7:0] i_ext_status,
  input wire i_ext_exec,
  input wire i_page_mode,
  input wire i_far_isr,
  input wire i_ext_stack,
  input wire i_far_stack,
  input wire [3:0] i_wait_states,
  output reg o_ctx_req,
  output reg o_vec_busy,
  output reg o_push_valid,
  output reg [7:0] o_push_data,
  output reg o_pc_load,
  output reg [23:0] o_vector_addr,
  output reg o_pop_valid,
  output reg o_call_push_valid,
  output reg [2:0] o_stack_count
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ = 2'h1;
  localparam [1:0] ST_SWITCH = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // state-time window
  reg hq_q;
  reg [1:0] slot_q;
  wire st_end = (hq_q == `IPVS_HALF_LAST);
  // (RULE_01) one poll per window
  wire poll_now = st_end && (slot_q == `IPVS_SLOT_LAST);

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hq_q <= `IPVS_HALF_FIRST;
      slot_q <= 2'h0;
    end else begin
      // (RULE_18) free-running window counter
      hq_q <= ~hq_q;
      if (st_end)
        slot_q <= slot_q + `IPVS_SLOT_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source sampling
  // pins sit at index 0 and 2, both active low
  wire [7:0] src = {i_int_req[5:2], i_int_req[1], ~i_ext_irq_pin_b_n, i_int_req[0], ~i_ext_irq_pin_a_n};
  wire [7:0] pend;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pair
      // (RULE_07) pins resampled only in their own slot
      ipvs_pair_latch #(
        .SLOT(g[1:0]),
        .EXT_LO((g < 2) ? 1'h1 : 1'h0),
        .EXT_HI(1'h0)
      ) u_pair (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_half(hq_q),
        .i_slot(slot_q),
        .i_src(src[2*g+1:2*g]),
        .o_pend(pend[2*g+1:2*g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers and Avalon slave
  reg [7:0] ien_q;
  reg stk_q;
  reg [15:0] prio_q;
  reg [3:0] isv_q;
  reg [3:0] srcsel_q;
  reg [1:0] fsm_q;
  wire req = i_avs_read | i_avs_write;
  wire wr_fire = i_avs_write && !o_avs_waitrequest;
  wire wr_ctrl = wr_fire && (i_avs_address == `IPVS_ADDR_CTRL);
  wire wr_prio = wr_fire && (i_avs_address == `IPVS_ADDR_PRIO);
  reg [31:0] rd_mux;

  always @* begin
    case (i_avs_address)
      `IPVS_ADDR_CTRL: rd_mux = {23'h000000, stk_q, ien_q};
      `IPVS_ADDR_PRIO: rd_mux = {16'h0000, prio_q};
      `IPVS_ADDR_STAT: rd_mux = {12'h000, srcsel_q, 3'h0, (fsm_q != ST_IDLE), isv_q, pend};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'h1;
      o_avs_readdata <= 32'h00000000;
      ien_q <= 8'h00;
      stk_q <= 1'h0;
      prio_q <= 16'h0000;
    end else begin
      // one wait state, then answer
      if (req && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'h0;
        o_avs_readdata <= rd_mux;
      end else begin
        o_avs_waitrequest <= 1'h1;
      end
      if (wr_ctrl && i_avs_byteenable[0])
        ien_q <= i_avs_writedata[7:0];
      if (wr_ctrl && i_avs_byteenable[1])
        stk_q <= i_avs_writedata[`IPVS_CTRL_STK_BIT];
      if (wr_prio && i_avs_byteenable[0])
        prio_q[7:0] <= i_avs_writedata[7:0];
      if (wr_prio && i_avs_byteenable[1])
        prio_q[15:8] <= i_avs_writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // priority resolution and blocking
  reg best_ok;
  reg [3:0] best_idx;
  reg [1:0] best_lvl;
  reg cur_ok;
  reg [1:0] cur_lvl;
  reg [3:0] isv_top;
  integer i;

  always @* begin
    best_ok = 1'h0;
    best_idx = 4'h0;
    best_lvl = 2'h0;
    // (RULE_08) single highest request, lowest index on ties
    for (i = `IPVS_NSRC - 1; i >= 0; i = i - 1) begin
      if (pend[i] && ien_q[i] && (!best_ok || prio_q[2*i +: 2] >= best_lvl)) begin
        best_ok = 1'h1;
        best_idx = i[3:0];
        best_lvl = prio_q[2*i +: 2];
      end
    end
    cur_ok = 1'h0;
    cur_lvl = 2'h0;
    isv_top = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (isv_q[i]) begin
        cur_ok = 1'h1;
        cur_lvl = i[1:0];
      end
    end
    if (cur_ok)
      isv_top[cur_lvl] = 1'h1;
  end

  reg [1:0] hold_q;
  reg trap_q;
  // (RULE_09) equal or higher level in service blocks
  wire lvl_block = cur_ok && (best_lvl <= cur_lvl);
  // (RULE_10) instruction boundary only
  // (RULE_11) hold after blocking instruction
  wire may_vec = poll_now && (fsm_q == ST_IDLE) && i_last_cycle && (hold_q == 2'h0);
  wire go_trap = may_vec && trap_q;
  wire go_irq = may_vec && !trap_q && best_ok && !lvl_block;
  wire [3:0] isv_set = go_irq ? (4'h1 << best_lvl) : 4'h0;
  wire [3:0] isv_clr = i_ret_stacked_context_select ? isv_top : 4'h0;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 2'h0;
      trap_q <= 1'h0;
      isv_q <= 4'h0;
    end else begin
      // (RULE_11) count completed instructions
      if (i_ret_stacked_context_select || wr_ctrl || wr_prio)
        hold_q <= `IPVS_HOLD_INSTR;
      else if (i_instr_end && hold_q != 2'h0)
        hold_q <= hold_q - `IPVS_HOLD_STEP;
      trap_q <= (trap_q & ~go_trap) | i_trap;
      // (RULE_09) in service until return, set wins
      isv_q <= (isv_q & ~isv_clr) | isv_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector cycle
  reg [5:0] cnt_q;
  reg [2:0] byte_q;
  reg [2:0] npush_q;
  reg [23:0] pc_q;
  reg [7:0] stat_q;
  wire [5:0] stk_add = !i_ext_stack ? 6'h00 : (i_far_stack ? `IPVS_ADD_STK_FAR : `IPVS_ADD_STK_NEAR);
  // (RULE_17) added states per condition
  wire [5:0] sw_len = `IPVS_CTX_STATES + (i_ext_exec ? `IPVS_ADD_EXT_EXEC : 6'h00)
    + (i_page_mode ? `IPVS_ADD_PAGE : 6'h00) + (i_far_isr ? `IPVS_ADD_FAR_ISR : 6'h00)
    + stk_add + {2'h0, i_wait_states};
  wire [23:0] irq_vec = `IPVS_VEC_BASE + ({20'h00000, srcsel_q} << `IPVS_VEC_STEP_SH);
  reg [7:0] push_byte;

  always @* begin
    case (byte_q)
      3'h0: push_byte = pc_q[7:0];
      3'h1: push_byte = pc_q[15:8];
      3'h2: push_byte = pc_q[23:16];
      default: push_byte = stat_q;
    endcase
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fsm_q <= ST_IDLE;
      cnt_q <= 6'h00;
      byte_q <= 3'h0;
      npush_q <= 3'h0;
      pc_q <= 24'h000000;
      stat_q <= 8'h00;
      srcsel_q <= 4'h0;
      o_ctx_req <= 1'h0;
      o_vec_busy <= 1'h0;
      o_push_valid <= 1'h0;
      o_push_data <= 8'h00;
      o_pc_load <= 1'h0;
      o_vector_addr <= 24'h000000;
    end else begin
      o_push_valid <= 1'h0;
      o_pc_load <= 1'h0;
      case (fsm_q)
        ST_IDLE: begin
          if (go_trap || go_irq) begin
            // (RULE_03) one request state
            fsm_q <= ST_REQ;
            o_ctx_req <= 1'h1;
            o_vec_busy <= 1'h1;
            srcsel_q <= go_trap ? `IPVS_SRC_TRAP : best_idx;
            pc_q <= i_pc;
            stat_q <= i_ext_status;
            // (RULE_13) four bytes with stacked context
            npush_q <= stk_q ? `IPVS_PUSH_CTX : `IPVS_PUSH_PC;
            cnt_q <= sw_len - `IPVS_CNT_ONE;
            byte_q <= 3'h0;
          end
        end
        ST_REQ: begin
          if (st_end) begin
            fsm_q <= ST_SWITCH;
            o_ctx_req <= 1'h0;
          end
        end
        ST_SWITCH: begin
          if (st_end) begin
            // (RULE_12) push program counter bytes
            if (byte_q < npush_q) begin
              o_push_valid <= 1'h1;
              o_push_data <= push_byte;
              byte_q <= byte_q + `IPVS_BYTE_STEP;
            end
            if (cnt_q == 6'h00) begin
              fsm_q <= ST_IDLE;
              o_vec_busy <= 1'h0;
              o_pc_load <= 1'h1;
              // (RULE_16) eight-byte spacing, trap apart
              o_vector_addr <= (srcsel_q == `IPVS_SRC_TRAP) ? `IPVS_VEC_TRAP : irq_vec;
            end else begin
              cnt_q <= cnt_q - `IPVS_CNT_ONE;
            end
          end
        end
        default: fsm_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return and call stack counts
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pop_valid <= 1'h0;
      o_call_push_valid <= 1'h0;
      o_stack_count <= 3'h0;
    end else begin
      o_pop_valid <= i_ret_stacked_context_select | i_ret_sub;
      o_call_push_valid <= i_call_sub;
      // (RULE_13) return pops what entry pushed
      if (i_ret_stacked_context_select)
        o_stack_count <= stk_q ? `IPVS_PUSH_CTX : `IPVS_PUSH_PC;
      // (RULE_14) subroutine moves two bytes
      else if (i_ret_sub || i_call_sub)
        o_stack_count <= `IPVS_PUSH_PC;
    end
  end
endmodule
